//--- inc/rcw_pkg.sv
// constants for the root-complex window and graphics control registers
package rcw_pkg;
	// config space offsets (byte address; 4ch and 50h are dwords, 52h is the 16-bit word)
	localparam logic [7:0]  RCW_OFS_WINDOW_BASE = 8'h4c;
	localparam logic [7:0]  RCW_OFS_GFX_CTRL_DW = 8'h50;
	localparam logic [7:0]  RCW_OFS_GFX_CTRL    = 8'h52;
	// window base field and reset
	localparam int          RCW_BASE_LSB        = 12;
	localparam logic [19:0] RCW_BASE_RESET      = 20'h0_0000;
	// graphics control field positions inside the 16-bit register
	localparam int          RCW_GMS_LSB         = 4;
	localparam int          RCW_LVD_BIT         = 1;
	// graphics control positions inside the 32-bit dword at 50h
	localparam int          RCW_GGC_DW_LSB      = 16;
	localparam logic [15:0] RCW_GGC_RESET       = 16'h0030;
	localparam logic [2:0]  RCW_GMS_RESET       = 3'h3;
	localparam logic        RCW_LVD_RESET       = 1'b0;
	// class sub-class codes
	localparam logic [7:0]  RCW_SUBCLASS_VGA    = 8'h00;
	localparam logic [7:0]  RCW_SUBCLASS_OTHER  = 8'h80;
	// pre-allocation sizes
	localparam logic [31:0] RCW_SIZE_1MB        = 32'h0010_0000;
	localparam logic [31:0] RCW_SIZE_8MB        = 32'h0080_0000;
	localparam logic [31:0] RCW_SIZE_NONE       = 32'h0000_0000;

	// memory size selector codes
	typedef enum logic [2:0] {
		RCW_GMS_NONE = 3'b000,
		RCW_GMS_1MB  = 3'b001,
		RCW_GMS_RSV2 = 3'b010,
		RCW_GMS_8MB  = 3'b011
	} rcw_gms_t;
endpackage : rcw_pkg

//--- logic/rcw_regs.sv
// root-complex window base and graphics control configuration registers
// Function
// - window base: 32 bits, bits 31:12 r/w reset zero, 11:0 reserved.
// - a 4 KB aligned window at the base routes to the register block.
// - after reset the window is off until enable bit 29 at 54h is set.
// - enable 0 claims no memory; enable 1 claims window accesses.
// - the 4 kB window never aliases onto any other memory space.
// - gfx control: 16 bits at 52-53h, reset 0030h, selector 6:4 = 011.
// - selector 000 allocates nothing, no VGA claims, sub-class 80.
// - selector 001 allocates 1 MB, 011 8 MB; other codes reserved.
// - the allocation starts at top of low usable memory minus size.
// - once the system RAM lock is set the selector ignores writes.
// - legacy video disable 0 with a nonzero selector: graphics claims VGA, sub-class 00.
// - legacy video disable 1: no VGA claims, sub-class 80.
`timescale 1ns/1ps
module rcw_regs
	import rcw_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// configuration space access, dword address with byte enables
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic [31:0]      cfg_rdata,
	output logic             cfg_rvalid,
	// state held in neighbouring registers
	input  wire logic        rc_window_enable,
	input  wire logic        sysmgmt_ram_lock,
	input  wire logic [31:0] top_low_usable_mem,
	// memory request decode
	input  wire logic        mem_valid,
	input  wire logic [31:0] mem_addr,
	output logic             rc_window_claim,
	// graphics device steering
	output logic             gfx_vga_claim,
	output logic [7:0]       gfx_subclass,
	output logic [31:0]      gfx_prealloc_size,
	output logic [31:0]      gfx_prealloc_base
);
	logic [19:0] base_reg;
	logic [2:0]  gms_reg;
	logic        lvd_reg;
	logic        win_hit;
	logic        vga_on;
	logic [31:0] size_now;

	// selector to bytes; reserved codes allocate nothing
	function automatic logic [31:0] gms_size(input logic [2:0] sel);
		logic [31:0] s;
		s = RCW_SIZE_NONE;
		case (sel)
			RCW_GMS_1MB: s = RCW_SIZE_1MB;
			RCW_GMS_8MB: s = RCW_SIZE_8MB;
			default:     s = RCW_SIZE_NONE;
		endcase
		return s;
	endfunction : gms_size

	// window base: bytes 1..3 carry bits 31:12, low nibble of byte 1 reserved
	always_ff @(posedge core_clk)
	begin
		if (rst)
			base_reg <= RCW_BASE_RESET;
		else if (cfg_wr && cfg_addr == RCW_OFS_WINDOW_BASE)
		begin
			if (cfg_be[1])
				base_reg[3:0] <= cfg_wdata[15:12];
			if (cfg_be[2])
				base_reg[11:4] <= cfg_wdata[23:16];
			if (cfg_be[3])
				base_reg[19:12] <= cfg_wdata[31:24];
		end
	end

	// graphics control selector, frozen by the system RAM lock
	always_ff @(posedge core_clk)
	begin
		if (rst)
			gms_reg <= RCW_GMS_RESET;
		else if (cfg_wr && cfg_addr == RCW_OFS_GFX_CTRL_DW && cfg_be[2]
			&& !sysmgmt_ram_lock)
			gms_reg <= cfg_wdata[RCW_GGC_DW_LSB + RCW_GMS_LSB +: 3];
	end

	// legacy video disable; only bit 1 of the low byte is kept
	always_ff @(posedge core_clk)
	begin
		if (rst)
			lvd_reg <= RCW_LVD_RESET;
		else if (cfg_wr && cfg_addr == RCW_OFS_GFX_CTRL_DW && cfg_be[2])
			lvd_reg <= cfg_wdata[RCW_GGC_DW_LSB + RCW_LVD_BIT];
	end

	// read path, one cycle after the request; reserved bits return zero
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cfg_rdata  <= 32'h0000_0000;
			cfg_rvalid <= 1'b0;
		end
		else
		begin
			cfg_rvalid <= cfg_rd;
			if (!cfg_rd)
				cfg_rdata <= 32'h0000_0000;
			else if (cfg_addr == RCW_OFS_WINDOW_BASE)
				cfg_rdata <= {base_reg, 12'h000};
			else if (cfg_addr == RCW_OFS_GFX_CTRL_DW)
				cfg_rdata <= {9'h000, gms_reg, 2'b00, lvd_reg, 1'b0,
					16'h0000};
			else
				cfg_rdata <= 32'h0000_0000;
		end
	end

	// window decode lives in its own module so the compare is registered once
	rcw_win_decode u_win (
		.core_clk (core_clk),
		.rst      (rst),
		.base     (base_reg),
		.enable   (rc_window_enable),
		.mem_valid(mem_valid),
		.mem_addr (mem_addr),
		.hit      (win_hit)
	);

	assign rc_window_claim = win_hit; // flop output of the decoder

	// vga claiming needs both a nonzero selector and legacy video enabled
	assign vga_on   = (gms_reg != RCW_GMS_NONE)
		&& !lvd_reg;
	assign size_now = gms_size(gms_reg);

	// graphics steering outputs, registered for clean timing
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			gfx_vga_claim     <= 1'b0;
			gfx_subclass      <= RCW_SUBCLASS_OTHER;
			gfx_prealloc_size <= RCW_SIZE_NONE;
			gfx_prealloc_base <= 32'h0000_0000;
		end
		else
		begin
			gfx_vga_claim     <= vga_on;
			gfx_subclass      <= vga_on ? RCW_SUBCLASS_VGA
				: RCW_SUBCLASS_OTHER;
			gfx_prealloc_size <= size_now;
			gfx_prealloc_base <= top_low_usable_mem - size_now;
		end
	end

	// checks
	a_win_off_quiet: assert property (
		@(posedge core_clk) disable iff (rst)
		!rc_window_enable |=> !rc_window_claim)
		else $error("window claimed while disabled");
	a_win_reset_off: assert property (
		@(posedge core_clk)
		rst |=> !rc_window_claim && base_reg == RCW_BASE_RESET)
		else $error("window not off after reset");
	a_win_claim_on: assert property (
		@(posedge core_clk) disable iff (rst)
		mem_valid && rc_window_enable
		&& mem_addr[31:RCW_BASE_LSB] == base_reg
		|=> rc_window_claim)
		else $error("window access not claimed");
	a_base_read_back: assert property (
		@(posedge core_clk) disable iff (rst)
		cfg_rd && cfg_addr == RCW_OFS_WINDOW_BASE |=> cfg_rvalid
		&& cfg_rdata[RCW_BASE_LSB-1:0] == 12'h000
		&& cfg_rdata[31:RCW_BASE_LSB] == $past(base_reg))
		else $error("window base read wrong");
	a_gms_lock_hold: assert property (
		@(posedge core_clk) disable iff (rst)
		sysmgmt_ram_lock |=> $stable(gms_reg))
		else $error("selector changed while locked");
	a_ggc_reset_val: assert property (
		@(posedge core_clk)
		rst |=> gms_reg == RCW_GMS_RESET && lvd_reg == RCW_LVD_RESET)
		else $error("graphics control reset wrong");
	a_sub_none_80: assert property (
		@(posedge core_clk) disable iff (rst)
		gms_reg == RCW_GMS_NONE || lvd_reg
		|=> gfx_subclass == RCW_SUBCLASS_OTHER && !gfx_vga_claim)
		else $error("vga still claimed");
	a_sub_vga_00: assert property (
		@(posedge core_clk) disable iff (rst)
		gms_reg != RCW_GMS_NONE && !lvd_reg
		|=> gfx_subclass == RCW_SUBCLASS_VGA && gfx_vga_claim)
		else $error("vga not claimed");
	a_prealloc_8mb: assert property (
		@(posedge core_clk) disable iff (rst)
		gms_reg == RCW_GMS_8MB |=> gfx_prealloc_size == RCW_SIZE_8MB
		&& gfx_prealloc_base == $past(top_low_usable_mem) - RCW_SIZE_8MB)
		else $error("8 MB allocation wrong");
	a_ggc_rsvd_zero: assert property (
		@(posedge core_clk) disable iff (rst)
		cfg_rd && cfg_addr == RCW_OFS_GFX_CTRL_DW
		|=> cfg_rdata[31:23] == 9'h000 && cfg_rdata[19:18] == 2'b00
		&& cfg_rdata[16] == 1'b0)
		else $error("reserved bits not zero");
	// strobe and answer pair one to one; a lost answer hands the host stale data
	a_rvalid_follow: assert property (
		@(posedge core_clk) disable iff (rst)
		cfg_rd |=> cfg_rvalid)
		else $error("read not answered");
	a_rdata_idle_zero: assert property (
		@(posedge core_clk) disable iff (rst)
		!cfg_rd |=> !cfg_rvalid && cfg_rdata == 32'h0000_0000)
		else $error("read data not idle");
	a_ggc_read_back: assert property (
		@(posedge core_clk) disable iff (rst)
		cfg_rd && cfg_addr == RCW_OFS_GFX_CTRL_DW
		|=> cfg_rdata[RCW_GGC_DW_LSB + RCW_GMS_LSB +: 3] == $past(gms_reg)
		&& cfg_rdata[RCW_GGC_DW_LSB + RCW_LVD_BIT] == $past(lvd_reg))
		else $error("graphics control read wrong");
	// an open selector must take every write, or the lock check proves nothing
	a_gms_write_open: assert property (
		@(posedge core_clk) disable iff (rst)
		cfg_wr && cfg_addr == RCW_OFS_GFX_CTRL_DW && cfg_be[2]
		&& !sysmgmt_ram_lock
		|=> gms_reg == $past(cfg_wdata[RCW_GGC_DW_LSB + RCW_GMS_LSB +: 3]))
		else $error("selector write lost");
	a_size_1mb: assert property (
		@(posedge core_clk) disable iff (rst)
		gms_reg == RCW_GMS_1MB |=> gfx_prealloc_size == RCW_SIZE_1MB
		&& gfx_prealloc_base == $past(top_low_usable_mem) - RCW_SIZE_1MB)
		else $error("1 MB allocation wrong");
	a_size_none_rsvd: assert property (
		@(posedge core_clk) disable iff (rst)
		gms_reg != RCW_GMS_1MB && gms_reg != RCW_GMS_8MB
		|=> gfx_prealloc_size == RCW_SIZE_NONE)
		else $error("reserved selector allocated memory");

	c_win_claim: cover property (@(posedge core_clk) rc_window_claim);
	c_lock_write: cover property (@(posedge core_clk)
		sysmgmt_ram_lock && cfg_wr && cfg_addr == 8'h50 && cfg_be[2]);
	c_gms_1mb: cover property (@(posedge core_clk) gms_reg == 3'b001);
	c_lvd_set: cover property (@(posedge core_clk) lvd_reg && gms_reg != 3'b000);
endmodule : rcw_regs

//--- logic/rcw_win_decode.sv
// registered 4 KB window decoder for the root-complex register block
`timescale 1ns/1ps
module rcw_win_decode
	import rcw_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// window programming
	input  wire logic [19:0] base,
	input  wire logic        enable,
	// memory request
	input  wire logic        mem_valid,
	input  wire logic [31:0] mem_addr,
	// claim result
	output logic             hit
);
	// full 20-bit compare: no partial decode, so the window never aliases
	always_ff @(posedge core_clk)
	begin
		if (rst)
			hit <= 1'b0;
		else
			hit <= mem_valid && enable &&
				(mem_addr[31:RCW_BASE_LSB] == base);
	end

	a_win_hit_exact: assert property (
		@(posedge core_clk) disable iff (rst)
		hit |-> $past(enable) && $past(mem_valid)
		&& ($past(mem_addr[31:RCW_BASE_LSB]) == $past(base)))
		else $error("window hit without exact match");
endmodule : rcw_win_decode

//--- sim/rcw_regs_bench.sv
// self-checking bench for the window base and graphics control registers
`timescale 1ns/1ps
module rcw_regs_bench;
	import rcw_pkg::*;
	// design connections
	logic        core_clk, rst, cfg_wr, cfg_rd, cfg_rvalid;
	logic        rc_window_enable, sysmgmt_ram_lock, mem_valid;
	logic        rc_window_claim, gfx_vga_claim;
	logic [7:0]  cfg_addr, gfx_subclass;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, top_low_usable_mem, mem_addr;
	logic [31:0] gfx_prealloc_size, gfx_prealloc_base, rd;
	int          fail_count = 0;
	int          cmp_count = 0;

	rcw_regs dut_u (.core_clk(core_clk), .rst(rst), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_rvalid(cfg_rvalid), .rc_window_enable(rc_window_enable),
		.sysmgmt_ram_lock(sysmgmt_ram_lock),
		.top_low_usable_mem(top_low_usable_mem), .mem_valid(mem_valid),
		.mem_addr(mem_addr), .rc_window_claim(rc_window_claim),
		.gfx_vga_claim(gfx_vga_claim), .gfx_subclass(gfx_subclass),
		.gfx_prealloc_size(gfx_prealloc_size),
		.gfx_prealloc_base(gfx_prealloc_base));

	// 40 MHz core clock
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic chk(input string what, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	// one-cycle write strobe, released at the next falling edge
	task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		cfg_wr = 1'b1; cfg_addr = a; cfg_be = be; cfg_wdata = d;
		@(negedge core_clk);
		cfg_wr = 1'b0;
	endtask : cfg_write

	// answer stands from the taking edge on, seen at the next negedge;
	// an idle cycle follows so the next read never re-raises the strobe
	// in the same step that lowered it, and the answer must drop again
	task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
		cfg_rd = 1'b1; cfg_addr = a; cfg_be = 4'hf;
		@(negedge core_clk);
		cfg_rd = 1'b0;
		chk("rvalid", {31'h0, cfg_rvalid}, 32'h1);
		d = cfg_rdata;
		@(negedge core_clk);
		chk("rvalid off", {31'h0, cfg_rvalid}, 32'h0);
		chk("rdata idle", cfg_rdata, 32'h0000_0000);
	endtask : cfg_read

	// one request cycle, then one idle cycle in which no claim may stand
	task automatic probe(input logic [31:0] a, input logic exp);
		mem_valid = 1'b1; mem_addr = a;
		@(negedge core_clk);
		mem_valid = 1'b0; mem_addr = ~a;
		chk("claim", {31'h0, rc_window_claim}, {31'h0, exp});
		@(negedge core_clk);
		chk("claim off", {31'h0, rc_window_claim}, 32'h0);
	endtask : probe

	// selector and legacy video disable sit in byte 2 of dword 50h
	task automatic gset(input logic [2:0] s, input logic l,
		input logic [31:0] sz, input logic v);
		cfg_write(RCW_OFS_GFX_CTRL_DW, 4'h4, {9'h0, s, 2'b0, l, 17'h0});
		repeat (2) @(negedge core_clk);
		chk("size", gfx_prealloc_size, sz);
		chk("pbase", gfx_prealloc_base, top_low_usable_mem - sz);
		chk("vga", {31'h0, gfx_vga_claim}, {31'h0, v});
		chk("sub", {24'h0, gfx_subclass}, v ? 32'h0 : 32'h80);
	endtask : gset

	task automatic t_reset();
		cfg_read(RCW_OFS_WINDOW_BASE, rd);
		chk("base rst", rd, 32'h0000_0000);
		cfg_read(RCW_OFS_GFX_CTRL_DW, rd);
		chk("gfx rst", rd, 32'h0030_0000);
		chk("size rst", gfx_prealloc_size, RCW_SIZE_8MB);
		chk("sub rst", {24'h0, gfx_subclass}, 32'h0);
		$display("reset test done");
	endtask : t_reset

	task automatic t_window();
		cfg_write(RCW_OFS_WINDOW_BASE, 4'hf, 32'hffff_ffff);
		cfg_read(RCW_OFS_WINDOW_BASE, rd);
		chk("base ones", rd, 32'hffff_f000);
		cfg_read(8'h60, rd);
		chk("unmapped", rd, 32'h0000_0000);
		cfg_write(RCW_OFS_WINDOW_BASE, 4'hf, 32'h1234_5abc);
		probe(32'h1234_5010, 1'b0);
		rc_window_enable = 1'b1;
		probe(32'h1234_5000, 1'b1);
		probe(32'h1234_5fff, 1'b1);
		probe(32'h1234_6000, 1'b0);
		probe(32'h1234_4fff, 1'b0);
		rc_window_enable = 1'b0;
		probe(32'h1234_5800, 1'b0);
		$display("window test done");
	endtask : t_window

	task automatic t_gfx();
		// graphics treated as disabled first: software parks the selector
		gset(3'b000, 1'b0, RCW_SIZE_NONE, 1'b0);
		gset(3'b001, 1'b0, RCW_SIZE_1MB, 1'b1);
		gset(3'b010, 1'b0, RCW_SIZE_NONE, 1'b1);
		gset(3'b011, 1'b1, RCW_SIZE_8MB, 1'b0);
		sysmgmt_ram_lock = 1'b1;
		gset(3'b001, 1'b0, RCW_SIZE_8MB, 1'b1);
		sysmgmt_ram_lock = 1'b0;
		cfg_write(RCW_OFS_GFX_CTRL_DW, 4'hf, 32'hffff_ffff);
		cfg_read(RCW_OFS_GFX_CTRL_DW, rd);
		chk("gfx rsv", rd, 32'h0072_0000);
		chk("size rsv", gfx_prealloc_size, RCW_SIZE_NONE);
		$display("graphics test done");
	endtask : t_gfx

	// main sequence: reset for 16 cycles, then the tests
	initial
	begin
		rst = 1'b1; cfg_wr = 1'b0; cfg_rd = 1'b0; cfg_addr = 8'h00;
		cfg_be = 4'h0; cfg_wdata = 32'h0000_0000; mem_valid = 1'b0;
		mem_addr = 32'h0000_0000; rc_window_enable = 1'b0;
		sysmgmt_ram_lock = 1'b0; top_low_usable_mem = 32'h0800_0000;
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		repeat (2) @(negedge core_clk);
		t_reset();
		t_window();
		t_gfx();
		complete_run();
	end

	// watchdog: the tests need well under 200 cycles
	initial
	begin
		#50000;
		fail_count++;
		complete_run();
	end
endmodule : rcw_regs_bench
